// [hw/ccf3_top.sv]
// Third core capability register with its coprocessor read/write port.
// Assumes one-cycle read and write strobes on the core clock.
`timescale 1ns/1ps

module ccf3_top
  import ccf3_pkg::*;
#(
  parameter logic [1:0] PRIO_WIDTH_CODE = CCF3_PW_EIGHT,
  parameter logic [2:0] COMPACT_REV = CCF3_REV_FIRST,
  parameter logic [1:0] INSTR_SET_AVAIL = CCF3_AV_BOTH_FULL,
  parameter bit ARCH_REL2 = 1'b1,
  parameter bit HAS_MCU = 1'b1,
  parameter bit HAS_ULR = 1'b1,
  parameter bit HAS_SPR2 = 1'b0,
  parameter bit HAS_SPE = 1'b0,
  parameter bit HAS_FLOW = 1'b0,
  parameter bit HAS_LARGE_ADDR = 1'b0,
  parameter bit HAS_EIC = 1'b1,
  parameter bit HAS_VEC_IRQ = 1'b1,
  parameter bit HAS_SPG = 1'b0,
  parameter bit HAS_CDM = 1'b0,
  parameter bit HAS_MTH = 1'b0,
  parameter bit HAS_SEC = 1'b0,
  parameter bit HAS_TRC = 1'b0
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic I_EXC_ISA_RESET,
  input wire logic I_CP_RD,
  input wire logic I_CP_WR,
  input wire logic [31:0] I_CP_WDATA,
  input wire logic [31:0] I_STATUS,
  input wire logic [31:0] I_CAUSE,
  output logic [31:0] O_CP_RDATA,
  output logic O_CP_RVALID,
  output logic O_EXC_ENTRY_COMPACT,
  output logic [7:0] O_STATUS_PRIO,
  output logic [7:0] O_REQ_PRIO
);

  // ****************************************************************
  // Preset fields and the writable entry-set bit
  // ****************************************************************

  ccf3_word_s word;
  logic exc_isa_r;
  logic exc_isa_nxt;
  logic exc_isa_fixed;
  logic exc_isa_fixed_val;
  logic [31:0] rdata_r;
  logic rvalid_r;
  logic exc_out_r;
  ccf3_prio_s prio;

  // Assemble the visible word
  always_comb begin
    // [RL21] no further config
    word.more_cfg = 1'b0;
    // [RL20] reserved read zero
    word.rsvd_hi = 8'h00;
    word.rsvd_12 = 1'b0;
    word.rsvd_9 = 1'b0;
    // [RL1] priority width preset
    word.priority_field_width = PRIO_WIDTH_CODE;
    // [RL4] compact revision preset
    word.compact_isa_revision = COMPACT_REV;
    // [RL5] controller extension flag
    word.mcu_present = HAS_MCU;
    // [RL6] writable entry set
    word.exception_entry_instr_set = exc_isa_r;
    // [RL8] set availability preset
    word.instr_set_avail = INSTR_SET_AVAIL;
    // [RL9] user-local flag
    word.user_local_reg_present = HAS_ULR;
    // [RL10] revision two flag
    word.signal_proc_rev2_present = HAS_SPR2;
    // [RL11] signal-processing flag
    word.signal_proc_ext_present = HAS_SPE;
    // [RL12] flow trace flag
    word.flow_trace_present = HAS_FLOW;
    word.large_phys_addr = HAS_LARGE_ADDR & ARCH_REL2;
    // [RL13] external controller flag
    word.external_irq_ctrl_present = HAS_EIC & ARCH_REL2;
    // [RL14] vectored flag, zero on first release
    word.vectored_irq_present = HAS_VEC_IRQ & ARCH_REL2;
    // [RL15] small page flag, zero on first release
    word.small_page_present = HAS_SPG & ARCH_REL2;
    // [RL16] device map flag
    word.common_device_map_present = HAS_CDM;
    // [RL17] multithread flag
    word.multithread_present = HAS_MTH;
    // [RL18] smart-card flag
    word.secure_card_ext_present = HAS_SEC;
    // [RL19] trace flag
    word.trace_present = HAS_TRC;
  end

  // ****************************************************************
  // Exception-entry instruction set bit
  // ****************************************************************

  // With a single set available the bit cannot name the missing one
  always_comb begin
    exc_isa_fixed = (INSTR_SET_AVAIL == CCF3_AV_FULL_ONLY) ||
                    (INSTR_SET_AVAIL == CCF3_AV_COMPACT_ONLY);
    exc_isa_fixed_val = (INSTR_SET_AVAIL == CCF3_AV_COMPACT_ONLY) ? CCF3_ISA_COMPACT
                                                                   : CCF3_ISA_FULL;
    exc_isa_nxt = exc_isa_r;
    // [RL22] only this bit writable
    if (I_CP_WR) begin
      exc_isa_nxt = I_CP_WDATA[CCF3_EXC_ISA_BIT];
    end
    if (exc_isa_fixed) begin
      exc_isa_nxt = exc_isa_fixed_val;
    end
  end

  // Reset value sampled from the outside strap while reset is held; a single-set preset loads its fixed set instead
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      // [RL7] strap gives reset value
      exc_isa_r <= exc_isa_fixed ? exc_isa_fixed_val : I_EXC_ISA_RESET;
    end else begin
      exc_isa_r <= exc_isa_nxt;
    end
  end

  // Registered copy of the bit for the vectoring logic
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      exc_out_r <= CCF3_ISA_FULL;
    end else begin
      exc_out_r <= exc_isa_r;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************

  // Read data registered; a read strobe returns the word next cycle
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      rdata_r <= CCF3_RDATA_RST;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= I_CP_RD;
      if (I_CP_RD) begin
        rdata_r <= word;
      end
    end
  end

  // ****************************************************************
  // Priority level extraction
  // ****************************************************************

  ccf3_prio_extract u_prio (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .i_width_code(PRIO_WIDTH_CODE),
    .i_status(I_STATUS),
    .i_cause(I_CAUSE),
    .o_prio(prio)
  );

  assign O_CP_RDATA = rdata_r;
  assign O_CP_RVALID = rvalid_r;
  assign O_EXC_ENTRY_COMPACT = exc_out_r;
  assign O_STATUS_PRIO = prio.status_priority_level;
  assign O_REQ_PRIO = prio.requested_priority_level;

endmodule

// [hw/ccf3_pkg.sv]
// Constants, field layout and codes for the third core capability register.
// Assumes a single core clock and a synchronous active-low reset.
//
// Contract
// [RL1] Read-only two-bit priority width: 0 gives six-bit fields, 1 eight-bit, rest reserved.
// [RL2] Eight-bit status priority: status bit 18 is MSB, bit 16 next.
// [RL3] Eight-bit requested priority: cause bit 17 is MSB, bit 16 next.
// [RL4] Read-only three-bit compact set revision; 0 is first release, 1-7 reserved.
// [RL5] Read-only bit, 1 when the microcontroller extension is implemented.
// [RL6] Writable bit picks exception-entry instruction set: 0 full, 1 compact.
// [RL7] Exception-entry set bit resets to an externally driven input value. With a single set available, the code loads that set and ignores the strap.
// [RL8] Read-only two-bit set availability: 32-bit, compact, both with either default.
// [RL9] Read-only bit, 1 when the user-local register is implemented.
// [RL10] Read-only bit, 1 when signal-processing extension revision two is implemented.
// [RL11] Read-only bit, 1 when the signal-processing extension is implemented.
// [RL12] Read-only bit, 1 when instruction flow trace is implemented.
// [RL13] Read-only bit, 1 when external interrupt controller mode is supported and present.
// [RL14] Read-only vectored interrupt bit; always zero on first-release architecture.
// [RL15] Read-only small page bit; always zero on first-release architecture.
// [RL16] Read-only bit, 1 when the common device memory map is implemented.
// [RL17] Read-only bit, 1 when the multithreading extension is implemented.
// [RL18] Read-only bit, 1 when the smart-card security extension is implemented.
// [RL19] Read-only bit, 1 when program-counter or data trace is implemented.
// [RL20] Reserved bits read zero; software writes zero to them.
// [RL21] Top bit reads zero; further configuration register absent.
// [RL22] Writes leave preset fields unchanged; only exception-entry set bit is writable.

package ccf3_pkg;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned CCF3_MORE_BIT = 31;
  localparam int unsigned CCF3_PRIO_W_LSB = 21;
  localparam int unsigned CCF3_REV_LSB = 18;
  localparam int unsigned CCF3_MCU_BIT = 17;
  localparam int unsigned CCF3_EXC_ISA_BIT = 16;
  localparam int unsigned CCF3_AVAIL_LSB = 14;
  localparam int unsigned CCF3_ULR_BIT = 13;
  localparam int unsigned CCF3_SPR2_BIT = 11;
  localparam int unsigned CCF3_SPE_BIT = 10;
  localparam int unsigned CCF3_FLOW_BIT = 8;
  localparam int unsigned CCF3_LARGE_ADDR_BIT = 7;
  localparam int unsigned CCF3_EIC_BIT = 6;
  localparam int unsigned CCF3_VEC_IRQ_BIT = 5;
  localparam int unsigned CCF3_SPG_BIT = 4;
  localparam int unsigned CCF3_CDM_BIT = 3;
  localparam int unsigned CCF3_MTH_BIT = 2;
  localparam int unsigned CCF3_SEC_BIT = 1;
  localparam int unsigned CCF3_TRC_BIT = 0;

  // ****************************************************************
  // Priority field placement in status and cause words
  // ****************************************************************
  localparam int unsigned CCF3_STAT_PRIO_MSB_BIT = 18;
  localparam int unsigned CCF3_CAUSE_PRIO_MSB_BIT = 17;
  localparam int unsigned CCF3_PRIO_SMSB_BIT = 16;
  localparam int unsigned CCF3_PRIO_LOW_LSB = 10;
  localparam int unsigned CCF3_PRIO_LOW_W = 6;
  localparam int unsigned CCF3_PRIO_MAX_W = 8;

  // ****************************************************************
  // Codes and reset values
  // ****************************************************************
  localparam logic [1:0] CCF3_PW_SIX = 2'h0;
  localparam logic [1:0] CCF3_PW_EIGHT = 2'h1;
  localparam logic [2:0] CCF3_REV_FIRST = 3'h0;
  localparam logic [1:0] CCF3_AV_FULL_ONLY = 2'h0;
  localparam logic [1:0] CCF3_AV_COMPACT_ONLY = 2'h1;
  localparam logic [1:0] CCF3_AV_BOTH_FULL = 2'h2;
  localparam logic [1:0] CCF3_AV_BOTH_COMPACT = 2'h3;
  localparam logic CCF3_ISA_FULL = 1'b0;
  localparam logic CCF3_ISA_COMPACT = 1'b1;
  localparam logic [31:0] CCF3_RDATA_RST = 32'h0000_0000;
  localparam logic [7:0] CCF3_PRIO_RST = 8'h00;

  // Register word layout, MSB first
  typedef struct packed {
    logic more_cfg;
    logic [7:0] rsvd_hi;
    logic [1:0] priority_field_width;
    logic [2:0] compact_isa_revision;
    logic mcu_present;
    logic exception_entry_instr_set;
    logic [1:0] instr_set_avail;
    logic user_local_reg_present;
    logic rsvd_12;
    logic signal_proc_rev2_present;
    logic signal_proc_ext_present;
    logic rsvd_9;
    logic flow_trace_present;
    logic large_phys_addr;
    logic external_irq_ctrl_present;
    logic vectored_irq_present;
    logic small_page_present;
    logic common_device_map_present;
    logic multithread_present;
    logic secure_card_ext_present;
    logic trace_present;
  } ccf3_word_s;

  // Decoded priority levels handed to the interrupt logic
  typedef struct packed {
    logic [7:0] status_priority_level;
    logic [7:0] requested_priority_level;
  } ccf3_prio_s;

endpackage

// [hw/ccf3_prio_extract.sv]
// Extracts status and requested priority levels from status and cause words.
// Assumes the width code is stable; output is registered one cycle later.
`timescale 1ns/1ps

module ccf3_prio_extract
  import ccf3_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_width_code,
  input wire logic [31:0] i_status,
  input wire logic [31:0] i_cause,
  output ccf3_prio_s o_prio
);

  ccf3_prio_s prio_nxt;
  ccf3_prio_s prio_r;

  // Gather one level; upper two bits only when the field is eight wide
  function automatic logic [7:0] pick_level(input logic [31:0] word, input logic [4:0] msb_pos,
                                            input logic wide);
    logic [7:0] lvl;
    lvl = {2'b00, word[CCF3_PRIO_LOW_LSB +: CCF3_PRIO_LOW_W]};
    if (wide) begin
      lvl[7] = word[msb_pos];
      lvl[6] = word[CCF3_PRIO_SMSB_BIT];
    end
    return lvl;
  endfunction

  // Combine both levels
  always_comb begin
    // [RL2] status level layout
    prio_nxt.status_priority_level = pick_level(i_status, 5'(CCF3_STAT_PRIO_MSB_BIT),
                                                i_width_code == CCF3_PW_EIGHT);
    // [RL3] requested level layout
    prio_nxt.requested_priority_level = pick_level(i_cause, 5'(CCF3_CAUSE_PRIO_MSB_BIT),
                                                   i_width_code == CCF3_PW_EIGHT);
  end

  // Register the levels
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      prio_r <= {CCF3_PRIO_RST, CCF3_PRIO_RST};
    end else begin
      prio_r <= prio_nxt;
    end
  end

  assign o_prio = prio_r;

endmodule

// [bench/ccf3_top_sva.sv]
// Checker for the third core capability register and its priority outputs.
// Bound to ccf3_top; sees only the top module's ports.
`timescale 1ns/1ps

module ccf3_top_chk
  import ccf3_pkg::*;
#(
  parameter logic [1:0] PRIO_WIDTH_CODE = CCF3_PW_EIGHT,
  parameter logic [1:0] INSTR_SET_AVAIL = CCF3_AV_BOTH_FULL
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic I_EXC_ISA_RESET,
  input wire logic I_CP_RD,
  input wire logic I_CP_WR,
  input wire logic [31:0] I_CP_WDATA,
  input wire logic [31:0] I_STATUS,
  input wire logic [31:0] I_CAUSE,
  input wire logic [31:0] O_CP_RDATA,
  input wire logic O_CP_RVALID,
  input wire logic O_EXC_ENTRY_COMPACT,
  input wire logic [7:0] O_STATUS_PRIO,
  input wire logic [7:0] O_REQ_PRIO
);
  logic wd16;
  logic [7:0] st_exp;
  logic [7:0] cs_exp;
  logic eight;

  // Expected priority levels for the preset width
  assign eight = (PRIO_WIDTH_CODE == CCF3_PW_EIGHT);
  assign wd16 = I_CP_WDATA[16];
  assign st_exp = eight ? {I_STATUS[18], I_STATUS[16], I_STATUS[15:10]} : {2'h0, I_STATUS[15:10]};
  assign cs_exp = eight ? {I_CAUSE[17], I_CAUSE[16], I_CAUSE[15:10]} : {2'h0, I_CAUSE[15:10]};

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  rd_answer_a: assert property (I_CP_RD |=> O_CP_RVALID &&
    O_CP_RDATA[31:23] == 9'h000)
    else $error("read answer missing or top bits set");
  rsv_low_a: assert property (O_CP_RVALID |-> !O_CP_RDATA[12] && !O_CP_RDATA[9])
    else $error("reserved bits read nonzero");
  width_code_a: assert property (O_CP_RVALID |-> O_CP_RDATA[22:21] == PRIO_WIDTH_CODE)
    else $error("priority width field wrong");
  avail_code_a: assert property (O_CP_RVALID |-> O_CP_RDATA[15:14] == INSTR_SET_AVAIL)
    else $error("set availability field wrong");
  rev_field_a: assert property (O_CP_RVALID |-> O_CP_RDATA[20:18] == CCF3_REV_FIRST)
    else $error("revision field wrong");
  exc_view_a: assert property (O_CP_RVALID |-> O_CP_RDATA[16] == O_EXC_ENTRY_COMPACT)
    else $error("entry set bit and output differ");
  single_set_a: assert property (!INSTR_SET_AVAIL[1] && O_CP_RVALID |->
    O_CP_RDATA[16] == INSTR_SET_AVAIL[0])
    else $error("entry set bit names a missing set");
  exc_write_a: assert property (I_CP_WR && INSTR_SET_AVAIL[1] |=> ##1
    O_EXC_ENTRY_COMPACT == $past(wd16, 2))
    else $error("entry set write not taken");
  strap_load_a: assert property ($rose(I_RST_N) && INSTR_SET_AVAIL[1] |=>
    O_EXC_ENTRY_COMPACT == $past(I_EXC_ISA_RESET, 2))
    else $error("entry set bit not loaded from strap");
  stat_prio_a: assert property ($past(I_RST_N) |-> O_STATUS_PRIO == $past(st_exp))
    else $error("status priority level wrong");
  req_prio_a: assert property ($past(I_RST_N) |-> O_REQ_PRIO == $past(cs_exp))
    else $error("requested priority level wrong");

  // Main scenarios
  cover property (I_CP_RD && I_CP_WR);
  cover property ($rose(I_RST_N) && I_EXC_ISA_RESET);
  cover property (O_CP_RVALID && O_CP_RDATA[16]);
endmodule

bind ccf3_top ccf3_top_chk #(.PRIO_WIDTH_CODE(PRIO_WIDTH_CODE), .INSTR_SET_AVAIL(INSTR_SET_AVAIL))
  i_ccf3_top_chk (.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_EXC_ISA_RESET(I_EXC_ISA_RESET),
  .I_CP_RD(I_CP_RD), .I_CP_WR(I_CP_WR), .I_CP_WDATA(I_CP_WDATA), .I_STATUS(I_STATUS),
  .I_CAUSE(I_CAUSE), .O_CP_RDATA(O_CP_RDATA), .O_CP_RVALID(O_CP_RVALID),
  .O_EXC_ENTRY_COMPACT(O_EXC_ENTRY_COMPACT), .O_STATUS_PRIO(O_STATUS_PRIO), .O_REQ_PRIO(O_REQ_PRIO));

// [bench/test_ccf3_top.sv]
// Self-checking bench for the third core capability register.
// Assumes default presets on the main copy: eight-bit width, both sets, several flags set.
// A second copy runs six-bit levels, compact set only and first-release flags.
`timescale 1ns/1ps

module test_ccf3_top;
  import ccf3_pkg::*;
  localparam logic [31:0] BASE = 32'h0022_A060;
  localparam logic [31:0] B16 = 32'h0001_0000;
  localparam logic [31:0] ALT = 32'h0003_6000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] stat = 32'h0;
  logic [31:0] cause = 32'h0;
  logic [31:0] rdata;
  logic rvalid;
  logic exc_out;
  logic [7:0] st_prio;
  logic [7:0] rq_prio;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] rdata_six;
  logic rvalid_six;
  logic exc_six;
  logic [7:0] st_six;
  logic [7:0] rq_six;

  ccf3_top i_ccf3_top (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_EXC_ISA_RESET(strap),
    .I_CP_RD(rd), .I_CP_WR(wr), .I_CP_WDATA(wdata), .I_STATUS(stat), .I_CAUSE(cause),
    .O_CP_RDATA(rdata), .O_CP_RVALID(rvalid), .O_EXC_ENTRY_COMPACT(exc_out),
    .O_STATUS_PRIO(st_prio), .O_REQ_PRIO(rq_prio));

  // Second copy: six-bit levels, compact set only, first-release flags
  ccf3_top #(.PRIO_WIDTH_CODE(CCF3_PW_SIX), .INSTR_SET_AVAIL(CCF3_AV_COMPACT_ONLY),
    .ARCH_REL2(1'b0)) i_ccf3_top_six (.I_CORE_CLK(clk), .I_RST_N(rst_n),
    .I_EXC_ISA_RESET(strap), .I_CP_RD(rd), .I_CP_WR(wr), .I_CP_WDATA(wdata), .I_STATUS(stat),
    .I_CAUSE(cause), .O_CP_RDATA(rdata_six), .O_CP_RVALID(rvalid_six),
    .O_EXC_ENTRY_COMPACT(exc_six), .O_STATUS_PRIO(st_six), .O_REQ_PRIO(rq_six));

  // Clock and hang guard
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic do_reset(input logic s);
    rst_n = 1'b0;
    strap = s;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, exc_out}, {31'h0, s});
  endtask

  task automatic rd_chk(input logic [31:0] exp);
    @(posedge clk);
    #1 rd = 1'b1;
    @(posedge clk);
    #1 rd = 1'b0;
    check({31'h0, rvalid}, 32'h1);
    check(rdata, exp);
  endtask

  task automatic wr_word(input logic [31:0] d);
    @(posedge clk);
    #1 wr = 1'b1;
    wdata = d;
    @(posedge clk);
    #1 wr = 1'b0;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_strap_and_writes();
    do_reset(1'b1);
    rd_chk(BASE | B16);
    wr_word(32'h0);
    @(posedge clk);
    #1;
    check({31'h0, exc_out}, 32'h0);
    // Ones everywhere except the reserved bits, which software keeps at zero
    wr_word(32'h807F_EDFF);
    rd_chk(BASE | B16);
    check({31'h0, exc_out}, 32'h1);
    $display("test strap_and_writes done");
  endtask

  task automatic t_same_cycle();
    wr_word(32'h0);
    @(posedge clk);
    #1 rd = 1'b1;
    wr = 1'b1;
    wdata = B16;
    @(posedge clk);
    #1 wr = 1'b0;
    check(rdata, BASE);
    @(posedge clk);
    #1 rd = 1'b0;
    check({31'h0, rvalid}, 32'h1);
    check(rdata, BASE | B16);
    $display("test same_cycle done");
  endtask

  task automatic t_prio();
    logic [31:0] pats [3] = '{32'h0005_A400, 32'hFFFA_FFFF, 32'h0001_0C00};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      #1 stat = pats[i];
      cause = ~pats[i];
      repeat (2) @(posedge clk);
      #1;
      check({24'h0, st_prio}, {24'h0, stat[18], stat[16], stat[15:10]});
      check({24'h0, rq_prio}, {24'h0, cause[17], cause[16], cause[15:10]});
      check({24'h0, st_six}, {26'h0, stat[15:10]});
      check({24'h0, rq_six}, {26'h0, cause[15:10]});
    end
    $display("test prio done");
  endtask

  task automatic t_mid_reset();
    do_reset(1'b0);
    rd_chk(BASE);
    $display("test mid_reset done");
  endtask

  // Single-set copy keeps the entry bit on the compact set despite strap and writes
  task automatic t_single_set();
    wr_word(32'h0);
    rd_chk(BASE);
    check({31'h0, rvalid_six}, 32'h1);
    check(rdata_six, ALT);
    check({31'h0, exc_six}, 32'h1);
    $display("test single_set done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    t_strap_and_writes();
    t_same_cycle();
    t_prio();
    t_mid_reset();
    t_single_set();
    end_of_test();
  end
endmodule
